// [logic/rcs_pkg.sv]
package rcs_pkg;
   // clock and timing
   localparam int CLK_HZ = 25_000_000;
   localparam int HFC_HZ = 25_000_000; // the core fast clock is clk_in itself
   localparam int MALF_RST_PERIODS = 24; // fast-clock periods, longest
   localparam int EXT_MIN_PERIODS = 12; // fast-clock periods, least
   localparam int MALF_RST_CYC = MALF_RST_PERIODS * CLK_HZ / HFC_HZ;
   localparam int EXT_MIN_CYC = (EXT_MIN_PERIODS * CLK_HZ + HFC_HZ - 1) / HFC_HZ;
   localparam logic [4:0] MALF_CNT = 5'(MALF_RST_CYC);
   localparam logic [4:0] EXT_MIN_CNT = 5'(EXT_MIN_CYC);
   localparam logic [3:0] LF_TICK_LAST = 4'hf; // slow clock modelled as 1 tick in 16
   localparam logic [15:0] RESET_VEC_ADDR = 16'hfffe;
   // fetch areas that trap
   localparam logic [15:0] SPF_AREA_LO = 16'h0000;
   localparam logic [15:0] SPF_AREA_HI = 16'h003f;
   localparam logic [15:0] RAM_AREA_LO = 16'h0040;
   localparam logic [15:0] RAM_AREA_HI = 16'h083f;
   localparam logic [15:0] DBUF_AREA_LO = 16'h0f80;
   localparam logic [15:0] DBUF_AREA_HI = 16'h0fff;
   // register word indices
   localparam logic [2:0] REG_SYSCTL2 = 3'h0;
   localparam logic [2:0] REG_WDTCTL1 = 3'h1;
   localparam logic [2:0] REG_INTEN = 3'h2;
   localparam logic [2:0] REG_LATCH = 3'h3;
   localparam logic [2:0] REG_STATUS = 3'h4;
   localparam logic [2:0] REG_IRQ_STAT = 3'h5;
   localparam logic [2:0] REG_IRQ_MASK = 3'h6;
   // field positions
   localparam int HF_EN_BIT = 7;
   localparam int LF_EN_BIT = 6;
   localparam int LF_SEL_BIT = 5;
   localparam int WDT_EN_BIT = 0;
   localparam int RAM_TRAP_BIT = 1;
   localparam int TRAP_RST_BIT = 2;
   localparam int EV_EXT = 0;
   localparam int EV_TRAP_RST = 1;
   localparam int EV_WDT_RST = 2;
   localparam int EV_CLK_RST = 3;
   localparam int EV_TRAP_INT = 4;
   localparam int EV_SWITCH = 5;
   localparam int NUM_EV = 6;
   // reset values
   localparam logic [2:0] WDTCTL1_RST = 3'h5;
   localparam logic [8:0] INTEN_RST = 9'h000;
   localparam logic [5:0] IRQ_MASK_RST = 6'h00;
   // operating modes, one hot
   localparam logic [3:0] MODE_FAST_SINGLE = 4'h1;
   localparam logic [3:0] MODE_FAST_DUAL = 4'h2;
   localparam logic [3:0] MODE_LF_DUAL = 4'h4;
   localparam logic [3:0] MODE_LF_ONLY = 4'h8;

   typedef struct packed {
      logic hf_en;
      logic lf_en;
      logic lf_sel;
   } rcs_clkctl_t;

   localparam rcs_clkctl_t CLKCTL_RST = '{hf_en: 1'b1, lf_en: 1'b0, lf_sel: 1'b0};

   typedef enum logic [2:0] {
      CS_HF = 3'b001,
      CS_LF = 3'b010,
      CS_SYNC = 3'b100
   } rcs_csw_t;
endpackage : rcs_pkg

// [logic/rcs_pin_filter.sv]
`timescale 1ns/1ps
`default_nettype none
module rcs_pin_filter
   import rcs_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic rst_pin_n_in,
   output logic hold_out
);
   logic [4:0] low_cnt;
   logic [4:0] next_low_cnt;

   // count consecutive low samples, saturating; a short glitch never resets the core
   always_comb begin
      next_low_cnt = low_cnt;
      if (rst_pin_n_in) begin
         next_low_cnt = 5'h00;
      end else if (low_cnt != EXT_MIN_CNT) begin
         next_low_cnt = low_cnt + 5'h01;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         low_cnt <= 5'h00;
      end else begin
         low_cnt <= next_low_cnt;
      end
   end

   assign hold_out = (low_cnt == EXT_MIN_CNT);

   sequence low_twelve;
      (!rst_pin_n_in)[*8] ##1 (!rst_pin_n_in)[*4];
   endsequence

   ext_min_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      low_twelve |=> hold_out)
      else $error("pin low for 12 cycles did not hold reset");
   ext_release_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      hold_out |-> $past(rst_pin_n_in) == 1'b0)
      else $error("reset held after pin returned high");
endmodule : rcs_pin_filter
`default_nettype wire

// [logic/rcs_malf_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module rcs_malf_timer
   import rcs_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic start_in,
   output logic busy_out
);
   logic [4:0] cnt;
   logic [4:0] next_cnt;

   // a window runs to its end even if the cause goes away; a new cause
   // arriving before the last cycle of a running window is absorbed by it; one in the last cycle restarts it
   always_comb begin
      next_cnt = cnt;
      if (start_in && cnt <= 5'h01) begin
         next_cnt = MALF_CNT;
      end else if (cnt != 5'h00) begin
         next_cnt = cnt - 5'h01;
      end
   end

   // power-up also opens a window: this logic is not trusted to be clean
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         cnt <= MALF_CNT;
      end else begin
         cnt <= next_cnt;
      end
   end

   assign busy_out = (cnt != 5'h00);

   malf_window_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      $rose(busy_out) |-> ##23 busy_out ##1 (!busy_out || $past(start_in)))
      else $error("malfunction reset window is not 24 cycles");
endmodule : rcs_malf_timer
`default_nettype wire

// [logic/rcs_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - After select is cleared the core stays on the slow clock until a slow tick aligns.
// - A low reset pin ends slow mode and release starts in single-clock fast mode.
// - Reset comes from the pin, an address trap, the watchdog or a clock fault.
// - A malfunction reset holds the core in reset for 24 fast-clock periods.
// - The malfunction timer is not cleared at power-up so one window follows power-on.
// - Reset clears master and individual interrupt enables, latches, and loads the vector.
// - Reset clears the timing prescaler and enables the watchdog.
// - The pin must be low 12 fast-clock periods before reset is applied.
// - When the pin returns high the core fetches its start address from the vector.
// - Fetches from the special-function or data-buffer area trap, and from RAM if selected.
// - A trap either resets for 24 periods or sets the trap interrupt latch.
// - Clearing both enables, or the enable of the selected clock, raises a clock reset.
module rcs_ctrl
   import rcs_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic rst_pin_n_in,
   input wire logic wdt_expire_in,
   input wire logic fetch_valid_in,
   input wire logic [15:0] fetch_addr_in,
   input wire logic [2:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output logic irq_out,
   output logic cpu_rst_out,
   output logic tg_clear_out,
   output logic vector_fetch_out,
   output logic [15:0] vector_addr_out,
   output logic hf_osc_en_out,
   output logic lf_osc_en_out,
   output logic hf_clk_sel_out,
   output logic [3:0] mode_out,
   output logic wdt_enable_out,
   output logic int_master_en_out,
   output logic [7:0] int_enable_out,
   output logic trap_int_out
);
   logic ext_hold;
   logic malf_busy;
   logic malf_start;
   logic rst_now;

   // the pin and the timed window together form the core reset
   rcs_pin_filter u_pin (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .rst_pin_n_in(rst_pin_n_in),
      .hold_out(ext_hold)
   );

   rcs_malf_timer u_malf (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .start_in(malf_start),
      .busy_out(malf_busy)
   );

   assign rst_now = ext_hold | malf_busy;

   // bus slave: one wait state, then the access completes
   logic wait_q;
   logic next_wait;
   logic [31:0] rdata_q;
   logic [31:0] next_rdata;
   logic [31:0] rd_mux;
   logic [31:0] be_mask;
   logic wr_go;

   generate
      for (genvar b = 0; b < 4; b++) begin : g_be
         assign be_mask[8*b +: 8] = {8{avs_byteenable_in[b]}};
      end
   endgenerate

   assign wr_go = avs_write_in & ~wait_q;

   // register state
   rcs_clkctl_t clk_q;
   rcs_clkctl_t next_clk;
   rcs_csw_t csw_q;
   rcs_csw_t next_csw;
   logic [3:0] lf_div_q;
   logic [3:0] next_lf_div;
   logic lf_tick;
   logic hf_sel_q;
   logic next_hf_sel;
   logic [3:0] mode_q;
   logic [3:0] next_mode;
   logic [2:0] wdtctl_q;
   logic [2:0] next_wdtctl;
   logic [8:0] inten_q;
   logic [8:0] next_inten;
   logic trap_lat_q;
   logic next_trap_lat;
   logic rst_q;
   logic vec_fetch_q;
   logic [15:0] vec_addr_q;
   logic [NUM_EV-1:0] stat_q;
   logic [NUM_EV-1:0] next_stat;
   logic [NUM_EV-1:0] mask_q;
   logic [NUM_EV-1:0] next_mask;
   logic [NUM_EV-1:0] ev;
   logic irq_q;
   logic ext_seen_q;

   // read data; reserved bits read as zero
   always_comb begin
      unique case (avs_address_in)
         REG_SYSCTL2: rd_mux = {24'h000000, clk_q, 5'h00};
         REG_WDTCTL1: rd_mux = {29'h00000000, wdtctl_q};
         REG_INTEN: rd_mux = {23'h000000, inten_q};
         REG_LATCH: rd_mux = {31'h00000000, trap_lat_q};
         REG_STATUS: rd_mux = {26'h0000000, rst_q, hf_sel_q, mode_q};
         REG_IRQ_STAT: rd_mux = {26'h0000000, stat_q};
         REG_IRQ_MASK: rd_mux = {26'h0000000, mask_q};
         default: rd_mux = 32'h00000000; // unmapped reads answer zero
      endcase
   end

   always_comb begin
      next_wait = 1'b1;
      next_rdata = rdata_q;
      if ((avs_read_in || avs_write_in) && wait_q) begin
         next_wait = 1'b0;
         next_rdata = avs_read_in ? rd_mux : 32'h00000000;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h00000000;
      end else begin
         wait_q <= next_wait;
         rdata_q <= next_rdata;
      end
   end

   // write merge and fault decode for the system control register
   logic [7:0] sys_old;
   logic [7:0] sys_new;
   logic sys_wr;
   logic clk_fault;

   assign sys_old = {clk_q, 5'h00};
   assign sys_new = (sys_old & ~be_mask[7:0]) | (avs_writedata_in[7:0] & be_mask[7:0]);
   assign sys_wr = wr_go && avs_address_in == REG_SYSCTL2 && !rst_now;

   // a write that clears both oscillator enables, or the enable of the clock selected before the write, is
   // refused and turned into a reset; a write that selects a clock whose oscillator is off is not refused
   always_comb begin
      clk_fault = 1'b0;
      if (sys_wr) begin
         if (!sys_new[HF_EN_BIT] && !sys_new[LF_EN_BIT] && (clk_q.hf_en || clk_q.lf_en)) begin
            clk_fault = 1'b1;
         end
         if (clk_q.hf_en && !sys_new[HF_EN_BIT] && !clk_q.lf_sel) begin
            clk_fault = 1'b1;
         end
         if (clk_q.lf_en && !sys_new[LF_EN_BIT] && clk_q.lf_sel) begin
            clk_fault = 1'b1;
         end
      end
   end

   // address trap decode
   logic in_spf;
   logic in_ram;
   logic in_dbuf;
   logic trap_hit;
   logic trap_rst;
   logic wdt_rst;

   assign in_spf = fetch_addr_in >= SPF_AREA_LO && fetch_addr_in <= SPF_AREA_HI;
   assign in_ram = fetch_addr_in >= RAM_AREA_LO && fetch_addr_in <= RAM_AREA_HI;
   assign in_dbuf = fetch_addr_in >= DBUF_AREA_LO && fetch_addr_in <= DBUF_AREA_HI;
   assign trap_hit = fetch_valid_in && !rst_q &&
                     (in_spf || in_dbuf || (in_ram && wdtctl_q[RAM_TRAP_BIT]));
   assign trap_rst = trap_hit && wdtctl_q[TRAP_RST_BIT];
   assign wdt_rst = wdt_expire_in && wdtctl_q[WDT_EN_BIT] && !rst_q;
   assign malf_start = trap_rst || wdt_rst || clk_fault;

   // slow clock tick from a divider; the crossover waits for it
   assign lf_tick = (lf_div_q == LF_TICK_LAST);
   assign next_lf_div = lf_div_q + 4'h1;

   // clock control, switch state and mode
   always_comb begin
      next_clk = clk_q;
      next_csw = csw_q;
      if (sys_wr && !clk_fault) begin
         next_clk = sys_new[HF_EN_BIT:LF_SEL_BIT];
      end
      unique case (csw_q)
         CS_HF: if (next_clk.lf_sel) next_csw = CS_LF;
         CS_LF: if (!next_clk.lf_sel) next_csw = CS_SYNC;
         CS_SYNC: begin
            if (next_clk.lf_sel) begin
               next_csw = CS_LF;
            end else if (lf_tick) begin
               next_csw = CS_HF;
            end
         end
      endcase
      if (rst_now) begin
         next_clk = CLKCTL_RST;
         next_csw = CS_HF;
      end
      next_hf_sel = (next_csw == CS_HF);
      if (next_hf_sel) begin
         next_mode = next_clk.lf_en ? MODE_FAST_DUAL : MODE_FAST_SINGLE;
      end else begin
         next_mode = next_clk.hf_en ? MODE_LF_DUAL : MODE_LF_ONLY;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         clk_q <= CLKCTL_RST;
         csw_q <= CS_HF;
         lf_div_q <= 4'h0;
         hf_sel_q <= 1'b1;
         mode_q <= MODE_FAST_SINGLE;
      end else begin
         clk_q <= next_clk;
         csw_q <= next_csw;
         lf_div_q <= next_lf_div;
         hf_sel_q <= next_hf_sel;
         mode_q <= next_mode;
      end
   end

   // core-side registers, all loaded with their reset values by any core reset
   always_comb begin
      next_wdtctl = wdtctl_q;
      next_inten = inten_q;
      next_trap_lat = trap_lat_q;
      if (wr_go && avs_address_in == REG_WDTCTL1 && avs_byteenable_in[0]) begin
         next_wdtctl = avs_writedata_in[2:0];
      end
      if (wr_go && avs_address_in == REG_INTEN) begin
         next_inten = (inten_q & ~be_mask[8:0]) | (avs_writedata_in[8:0] & be_mask[8:0]);
      end
      // the latch is cleared by software or by a core reset; a new trap wins over a software clear
      if (wr_go && avs_address_in == REG_LATCH && avs_byteenable_in[0]) begin
         next_trap_lat = trap_lat_q & avs_writedata_in[0];
      end
      if (trap_hit && !wdtctl_q[TRAP_RST_BIT]) begin
         next_trap_lat = 1'b1;
      end
      if (rst_now) begin
         next_wdtctl = WDTCTL1_RST;
         next_inten = INTEN_RST;
         next_trap_lat = 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         wdtctl_q <= WDTCTL1_RST;
         inten_q <= INTEN_RST;
         trap_lat_q <= 1'b0;
      end else begin
         wdtctl_q <= next_wdtctl;
         inten_q <= next_inten;
         trap_lat_q <= next_trap_lat;
      end
   end

   // reset output and the vector fetch on release
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rst_q <= 1'b1;
         vec_fetch_q <= 1'b0;
         vec_addr_q <= RESET_VEC_ADDR;
      end else begin
         rst_q <= rst_now;
         vec_fetch_q <= rst_q && !rst_now;
         vec_addr_q <= RESET_VEC_ADDR;
      end
   end

   // event flags survive the core reset so software can read the cause
   always_comb begin
      ev = '0;
      ev[EV_EXT] = ext_hold && !ext_seen_q;
      ev[EV_TRAP_RST] = trap_rst;
      ev[EV_WDT_RST] = wdt_rst;
      ev[EV_CLK_RST] = clk_fault;
      ev[EV_TRAP_INT] = trap_hit && !wdtctl_q[TRAP_RST_BIT];
      ev[EV_SWITCH] = csw_q == CS_SYNC && next_csw == CS_HF && !rst_now;
      next_stat = stat_q;
      next_mask = mask_q;
      if (wr_go && avs_address_in == REG_IRQ_STAT) begin
         next_stat = stat_q & ~(avs_writedata_in[NUM_EV-1:0] & be_mask[NUM_EV-1:0]);
      end
      if (wr_go && avs_address_in == REG_IRQ_MASK) begin
         next_mask = (mask_q & ~be_mask[NUM_EV-1:0]) |
                     (avs_writedata_in[NUM_EV-1:0] & be_mask[NUM_EV-1:0]);
      end
      next_stat = next_stat | ev; // set wins over a clear in the same cycle
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         stat_q <= '0;
         mask_q <= IRQ_MASK_RST;
         irq_q <= 1'b0;
         ext_seen_q <= 1'b0;
      end else begin
         stat_q <= next_stat;
         mask_q <= next_mask;
         irq_q <= |(next_stat & next_mask);
         ext_seen_q <= ext_hold;
      end
   end

   assign avs_readdata_out = rdata_q;
   assign avs_waitrequest_out = wait_q;
   assign irq_out = irq_q;
   assign cpu_rst_out = rst_q;
   assign tg_clear_out = rst_q;
   assign vector_fetch_out = vec_fetch_q;
   assign vector_addr_out = vec_addr_q;
   assign hf_osc_en_out = clk_q.hf_en;
   assign lf_osc_en_out = clk_q.lf_en;
   assign hf_clk_sel_out = hf_sel_q;
   assign mode_out = mode_q;
   assign wdt_enable_out = wdtctl_q[WDT_EN_BIT];
   assign int_master_en_out = inten_q[8];
   assign int_enable_out = inten_q[7:0];
   assign trap_int_out = trap_lat_q;

   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   sequence sync_wait;
      csw_q == CS_SYNC && !next_clk.lf_sel && !rst_now; // a select written back keeps it slow
   endsequence

   release_vector_a: assert property ($fell(cpu_rst_out) |->
      vector_fetch_out && vector_addr_out == 16'hfffe)
      else $error("no vector fetch at reset release");
   release_mode_a: assert property ($fell(cpu_rst_out) |->
      mode_out == MODE_FAST_SINGLE && hf_clk_sel_out)
      else $error("release not in single-clock fast mode");
   reset_clears_a: assert property (cpu_rst_out |->
      !int_master_en_out && int_enable_out == 8'h00 && !trap_int_out)
      else $error("interrupt state not cleared in reset");
   reset_wdt_a: assert property (cpu_rst_out |-> wdt_enable_out && tg_clear_out)
      else $error("watchdog not enabled in reset");
   trap_reset_a: assert property (trap_rst && !malf_busy |-> ##2 cpu_rst_out)
      else $error("trap fetch did not reset");
   trap_int_a: assert property (trap_hit && !wdtctl_q[TRAP_RST_BIT] && !rst_now |=>
      trap_int_out)
      else $error("trap did not set latch");
   clock_fault_a: assert property (clk_fault |=> $stable(clk_q) ##1 cpu_rst_out)
      else $error("clock fault did not reset");
   switch_sync_a: assert property (sync_wait |-> !hf_clk_sel_out ##1
      (hf_clk_sel_out == $past(lf_tick)))
      else $error("clock crossover not aligned to slow tick");
endmodule : rcs_ctrl
`default_nettype wire

// [sim/rcs_pin_src.sv]
`timescale 1ns/1ps
`default_nettype none
// far-side reset source: drives the pin low for a set count, pull-up level otherwise
module rcs_pin_src (
   input wire logic clk_in,
   input wire logic go_in,
   input wire logic [4:0] low_cyc_in,
   output logic rst_pin_n_out
);
   logic [4:0] left = 5'h00;
   // count the low phase down; a count below 12 is how a too-short pulse is made
   always @(posedge clk_in) begin
      if (go_in) begin
         left <= low_cyc_in;
      end else if (left != 5'h00) begin
         left <= left - 5'h01;
      end
   end
   assign rst_pin_n_out = (left == 5'h00);
endmodule : rcs_pin_src
`default_nettype wire

// [sim/test_reset_and_clock_switch_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module test_reset_and_clock_switch_ctrl;
   import rcs_pkg::*;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic wdt_x = 1'b0, f_v = 1'b0, rd = 1'b0, wr = 1'b0, pin_go = 1'b0, seen;
   logic [15:0] f_a = 16'h0000;
   logic [2:0] adr = 3'h0;
   logic [31:0] wd = 32'h0, rdata, rv;
   logic [4:0] low_cyc = 5'h0e;
   wire logic pin_n;
   logic waitreq, irq, cpu_rst, vec_f, hf_en, lf_en, hf_sel, wdt_en, interrupt_master_enable, trap_int, tg_clr;
   logic [15:0] vec_a;
   logic [3:0] mode;
   logic [7:0] ints;
   logic [31:0] fault_val [3] = '{32'h40, 32'h00, 32'ha0};
   int err_total = 0, checks_done = 0, n;

   // 25 MHz core clock
   always #20 clk_in = ~clk_in;

   rcs_pin_src src (.clk_in(clk_in), .go_in(pin_go), .low_cyc_in(low_cyc), .rst_pin_n_out(pin_n));
   rcs_ctrl dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .rst_pin_n_in(pin_n),
      .wdt_expire_in(wdt_x), .fetch_valid_in(f_v), .fetch_addr_in(f_a),
      .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
      .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
      .irq_out(irq), .cpu_rst_out(cpu_rst), .tg_clear_out(tg_clr), .vector_fetch_out(vec_f),
      .vector_addr_out(vec_a), .hf_osc_en_out(hf_en), .lf_osc_en_out(lf_en),
      .hf_clk_sel_out(hf_sel), .mode_out(mode), .wdt_enable_out(wdt_en),
      .int_master_en_out(interrupt_master_enable), .int_enable_out(ints), .trap_int_out(trap_int));

   // compare one value and count it
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test

   task automatic fail_to(input string what);
      err_total++;
      $display("[ERR] %s expected done seen timeout", what);
      finish_test();
   endtask : fail_to

   task automatic tick(input int k);
      repeat (k) @(posedge clk_in);
   endtask : tick

   // one bus cycle; the request stands until waitrequest is sampled low
   task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_in);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= ~w;
      i = 0;
      do begin
         @(posedge clk_in);
         i++;
      end while (waitreq !== 1'b0 && i < 50);
      rv = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      if (i >= 50) fail_to("bus");
   endtask : bus

   task automatic wr32(input logic [2:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr32

   task automatic rd_chk(input string what, input logic [2:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(what, exp, rv);
   endtask : rd_chk

   task automatic fetch(input logic [15:0] a);
      @(posedge clk_in);
      f_v <= 1'b1;
      f_a <= a;
      @(posedge clk_in);
      f_v <= 1'b0;
   endtask : fetch

   task automatic pulse_pin(input logic [4:0] k);
      @(posedge clk_in);
      low_cyc <= k;
      pin_go <= 1'b1;
      @(posedge clk_in);
      pin_go <= 1'b0;
   endtask : pulse_pin

   // waits for core reset and returns how many cycles it stood
   task automatic rst_len(output int len);
      int i;
      i = 0;
      len = 0;
      do begin
         @(posedge clk_in);
         i++;
      end while (cpu_rst !== 1'b1 && i < 60);
      if (i >= 60) fail_to("core reset");
      while (cpu_rst === 1'b1 && len < 200) begin
         @(posedge clk_in);
         len++;
      end
      chk("vector pulse", 32'h1, vec_f);
      chk("vector addr", RESET_VEC_ADDR, vec_a);
   endtask : rst_len

   initial begin
      tick(8);
      sys_rst_in <= 1'b0;
      // power-up window and reset state
      rst_len(n);
      // the first high sample is the state held by sys_rst_in, then the full window
      chk("power window", MALF_RST_PERIODS + 1, n);
      chk("mode", MODE_FAST_SINGLE, mode);
      chk("wdt enable", 32'h1, wdt_en);
      chk("tg clear", 32'h0, tg_clr);
      rd_chk("sysctl", REG_SYSCTL2, 32'h80);
      rd_chk("wdtctl", REG_WDTCTL1, 32'h5);
      rd_chk("unmapped", 3'h7, 32'h0);
      $display("test power-up done");
      // trap reset clears the enables; window stands its full length
      wr32(REG_INTEN, 32'h1ff);
      tick(2);
      chk("int enables", 32'hff, ints);
      chk("master enable", 32'h1, interrupt_master_enable);
      fetch(16'h0010);
      rst_len(n);
      chk("trap window", 32'd24, n);
      chk("int enables", 32'h0, ints);
      chk("master enable", 32'h0, interrupt_master_enable);
      $display("test trap reset done");
      // trap as interrupt, RAM select, irq raise, mask and clear
      wr32(REG_WDTCTL1, 32'h1);
      wr32(REG_IRQ_STAT, 32'h3f);
      wr32(REG_IRQ_MASK, 32'h10);
      fetch(16'h0100);
      tick(3);
      chk("ram no trap", 32'h0, trap_int);
      chk("irq idle", 32'h0, irq);
      wr32(REG_WDTCTL1, 32'h3);
      fetch(16'h0100);
      tick(3);
      chk("ram trap", 32'h1, trap_int);
      chk("no reset", 32'h0, cpu_rst);
      chk("irq raised", 32'h1, irq);
      wr32(REG_IRQ_STAT, 32'h10);
      wr32(REG_LATCH, 32'h0);
      tick(2);
      chk("irq cleared", 32'h0, irq);
      chk("latch cleared", 32'h0, trap_int);
      wr32(REG_IRQ_MASK, 32'h0);
      fetch(16'h0fa0);
      tick(3);
      chk("irq masked", 32'h0, irq);
      rd_chk("irq status", REG_IRQ_STAT, 32'h10);
      $display("test trap interrupt done");
      // watchdog reset
      wr32(REG_IRQ_STAT, 32'h3f);
      @(posedge clk_in);
      wdt_x <= 1'b1;
      @(posedge clk_in);
      wdt_x <= 1'b0;
      rst_len(n);
      chk("wdt window", 32'd24, n);
      rd_chk("wdt status", REG_IRQ_STAT, 32'h04);
      rd_chk("wdtctl again", REG_WDTCTL1, 32'h5);
      $display("test watchdog done");
      // fast dual to slow and back; the change to fast waits for a slow tick
      wr32(REG_SYSCTL2, 32'hc0);
      tick(2);
      chk("mode dual", MODE_FAST_DUAL, mode);
      chk("slow osc on", 32'h1, lf_en);
      wr32(REG_SYSCTL2, 32'he0);
      tick(2);
      chk("mode slow dual", MODE_LF_DUAL, mode);
      chk("slow clock", 32'h0, hf_sel);
      wr32(REG_SYSCTL2, 32'h60);
      tick(2);
      chk("mode slow only", MODE_LF_ONLY, mode);
      chk("fast osc off", 32'h0, hf_en);
      wr32(REG_SYSCTL2, 32'he0);
      tick(20);
      wr32(REG_SYSCTL2, 32'hc0);
      n = 0;
      while (hf_sel !== 1'b1 && n < 40) begin
         @(posedge clk_in);
         n++;
      end
      chk("sync wait", 32'h1, (n >= 1 && n <= 17));
      chk("mode back", MODE_FAST_DUAL, mode);
      rd_chk("switch status", REG_IRQ_STAT, 32'h24);
      $display("test clock switch done");
      // the three clock-fault writes
      for (int k = 0; k < 3; k++) begin
         wr32(REG_SYSCTL2, 32'hc0);
         if (k == 2) wr32(REG_SYSCTL2, 32'he0);
         wr32(REG_SYSCTL2, fault_val[k]);
         rst_len(n);
         chk("clock fault window", 32'd24, n);
         chk("fast osc kept", 32'h1, hf_en);
      end
      $display("test clock fault done");
      // short pin pulse ignored, long one ends slow mode
      pulse_pin(5'h08);
      seen = 1'b0;
      repeat (16) begin
         @(posedge clk_in);
         seen = seen | cpu_rst;
      end
      chk("short pin", 32'h0, seen);
      wr32(REG_SYSCTL2, 32'hc0);
      wr32(REG_SYSCTL2, 32'he0);
      wr32(REG_SYSCTL2, 32'h60);
      pulse_pin(5'h0e);
      rst_len(n);
      chk("mode after pin", MODE_FAST_SINGLE, mode);
      chk("fast clock", 32'h1, hf_sel);
      // clock-fault, watchdog and switch flags stay sticky from the earlier tests
      rd_chk("pin status", REG_IRQ_STAT, 32'h2d);
      $display("test pin reset done");
      finish_test();
   end
endmodule : test_reset_and_clock_switch_ctrl
`default_nettype wire
